/* File: bsc_pkg.sv */
package bsc_pkg;

	// default code: a (15,7) double-error-correcting code over 4-bit symbols
	localparam int           DEF_SYM_BITS = 4;
	localparam int           DEF_CW_LEN   = 15;
	localparam int           DEF_MSG_LEN  = 7;
	localparam int           DEF_T        = 2;
	localparam int           DEF_D        = 1;
	localparam logic [8:0]   DEF_GEN      = 9'h1d1;

	// output buffer geometry
	localparam int           FIFO_DEPTH   = 32;
	localparam int           FLAG_BITS    = 3;

	// field positions of a buffered word: {data, sop, eop, error}, error in bit 0
	localparam int           FLD_ERR      = 0;
	localparam int           FLD_EOP      = 1;
	localparam int           FLD_SOP      = 2;

	// mode selection
	localparam bit           MODE_ENCODER = 1'b1;
	localparam bit           MODE_DECODER = 1'b0;

	typedef enum logic [1:0] {
		ST_RECV = 2'b00,
		ST_CORR = 2'b01,
		ST_EMIT = 2'b10
	} bsc_state_t;

endpackage

/* File: bsc_stream_if.sv */
`timescale 1ns/1ps
// one valid/ready stream between the codec core and its output buffer
interface bsc_stream_if #(
	parameter int W = 8
) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

/* File: bsc_fifo.sv */
`timescale 1ns/1ps
module bsc_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = bsc_pkg::FIFO_DEPTH
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	bsc_stream_if.snk wr,
	bsc_stream_if.src rd
);
	import bsc_pkg::*;

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0]  wptr_q;
	logic [AW:0]  rptr_q;
	logic         full;
	logic         empty;
	logic         push;
	logic         pop;

	// extra pointer bit separates full from empty
	assign empty    = (wptr_q == rptr_q);
	assign full     = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data  = mem_q[rptr_q[AW-1:0]];     // head word sits in flops
	assign push     = wr.valid && !full;
	assign pop      = rd.ready && !empty;

	// storage has no reset: only words behind a valid pointer are ever read
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_q[wptr_q[AW-1:0]] <= wr.data;
		end
	end

	// pointers move only on a real transfer, so a stalled head stays put
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wptr_q <= '0;
			rptr_q <= '0;
		end else begin
			if (push) begin
				wptr_q <= wptr_q + 1'b1;
			end
			if (pop) begin
				rptr_q <= rptr_q + 1'b1;
			end
		end
	end

endmodule

/* File: bsc_codec.sv */
`timescale 1ns/1ps
module bsc_codec #(
	parameter bit               ENCODER  = bsc_pkg::MODE_ENCODER,
	parameter int               M        = bsc_pkg::DEF_SYM_BITS,
	parameter int               N        = bsc_pkg::DEF_CW_LEN,
	parameter int               K        = bsc_pkg::DEF_MSG_LEN,
	parameter int               T        = bsc_pkg::DEF_T,
	parameter int               D        = bsc_pkg::DEF_D,
	parameter logic [N-K:0]     GEN      = bsc_pkg::DEF_GEN,
	parameter int               DEPTH    = bsc_pkg::FIFO_DEPTH
) (
	input  wire logic           ref_clk,
	input  wire logic           rst_n,
	input  wire logic [D-1:0]   in_data,
	input  wire logic           in_valid,
	input  wire logic           in_sop,
	input  wire logic           in_eop,
	output logic                in_ready,
	output logic [D-1:0]        out_data,
	output logic                out_valid,
	output logic                out_sop,
	output logic                out_eop,
	output logic                out_error,
	input  wire logic           out_ready
);
	import bsc_pkg::*;

	localparam int P     = N - K;
	localparam int X_IN  = ENCODER ? (K / D) : (N / D);
	localparam int X_OUT = N / D;
	localparam int CW    = $clog2(X_IN + 1);
	localparam int OW    = $clog2(X_OUT + 1);
	localparam int PW    = $clog2(N + 1);
	localparam int FW    = D + FLAG_BITS;
	localparam int CORR_MAX = N + 1;

	// remainder of v(x)*x^P modulo the generator; nonzero exactly when v is not a codeword
	function automatic logic [P-1:0] poly_rem(input logic [N-1:0] v);
		logic [P-1:0] r;
		logic         fb;
		r = '0;
		for (int i = N - 1; i >= 0; i--) begin
			fb = r[P-1] ^ v[i];
			r  = {r[P-2:0], 1'b0};
			if (fb) begin
				r = r ^ GEN[P-1:0];
			end
		end
		return r;
	endfunction

	bsc_state_t     state_q;
	bsc_state_t     state_d;
	logic [CW-1:0]  cnt_q;
	logic [CW-1:0]  cnt_d;
	logic [OW-1:0]  ocnt_q;
	logic [OW-1:0]  ocnt_d;
	logic [N-1:0]   buf_q;
	logic [N-1:0]   buf_d;
	logic [P-1:0]   syn_q;
	logic [P-1:0]   syn_d;
	logic [PW-1:0]  pos_q;
	logic [PW-1:0]  pos_d;
	logic           fix_q;
	logic           fix_d;
	logic           err_q;
	logic           err_d;

	logic [N+D-1:0] in_cat;
	logic [N-1:0]   shifted;
	logic [N-1:0]   enc_msg;
	logic [N-1:0]   enc_cw;
	logic [N-1:0]   emit_next;
	logic           recv;
	logic           last_pend;
	logic           take;
	logic           take_last;
	logic           push;
	logic           push_last;
	logic [P-1:0]   pow_syn [N];
	logic           single_hit;
	logic           pair_hit;
	logic [PW-1:0]  pair_j;
	logic           hit;
	logic [N-1:0]   flip_mask;
	logic           corr_done;
	logic [FW-1:0]  head;

	bsc_stream_if #(.W(FW)) wr_s ();
	bsc_stream_if #(.W(FW)) rd_s ();

	// syndrome of a single error at each bit position, fixed at elaboration
	for (genvar gi = 0; gi < N; gi++) begin : g_pow
		assign pow_syn[gi] = poly_rem(N'(1) << gi);
	end

	// input acceptance: the last word is taken while ready is already low
	assign recv      = (state_q == ST_RECV);
	assign last_pend = recv && (cnt_q == CW'(X_IN - 1));
	assign in_ready  = recv && !last_pend;
	assign take      = in_valid && recv;
	assign take_last = take && last_pend;
	assign in_cat    = {buf_q, in_data};
	assign shifted   = in_cat[N-1:0];

	// encoder: message sits in the low K bits; parity appended below it
	assign enc_msg   = {{P{1'b0}}, shifted[K-1:0]};
	assign enc_cw    = {shifted[K-1:0], poly_rem(enc_msg)};

	// decoder search: one candidate position per cycle, partner searched in parallel
	assign single_hit = (pow_syn[pos_q] == syn_q);
	always_comb begin
		pair_hit = 1'b0;
		pair_j   = '0;
		for (int j = 0; j < N; j++) begin
			if ((T >= 2) && (PW'(j) > pos_q) && ((pow_syn[pos_q] ^ pow_syn[j]) == syn_q)) begin
				pair_hit = 1'b1;
				pair_j   = PW'(j);
			end
		end
	end
	assign hit       = !fix_q && (single_hit || pair_hit);
	assign flip_mask = !hit ? '0 :
	                   single_hit ? (N'(1) << pos_q) :
	                   ((N'(1) << pos_q) | (N'(1) << pair_j));
	assign corr_done = fix_q || hit || (pos_q == PW'(N - 1));

	// output side: words leave MSB first, marked with packet flags
	assign push      = wr_s.valid && wr_s.ready;
	assign push_last = push && (ocnt_q == OW'(X_OUT - 1));
	assign emit_next = {buf_q[N-D-1:0], {D{1'b0}}};
	assign wr_s.valid = (state_q == ST_EMIT);
	assign wr_s.data  = {buf_q[N-1 -: D], ocnt_q == '0, ocnt_q == OW'(X_OUT - 1),
	                     err_q};

	// next-state logic of the codec sequencer
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		ocnt_d  = ocnt_q;
		buf_d   = buf_q;
		syn_d   = syn_q;
		pos_d   = pos_q;
		fix_d   = fix_q;
		err_d   = err_q;
		case (state_q)
			ST_RECV: begin
				if (take) begin
					buf_d = shifted;
					cnt_d = cnt_q + 1'b1;
					if (take_last) begin
						cnt_d  = '0;
						ocnt_d = '0;
						pos_d  = '0;
						if (ENCODER) begin
							buf_d   = enc_cw;
							err_d   = 1'b0;
							state_d = ST_EMIT;
						end else begin
							syn_d   = poly_rem(shifted);
							fix_d   = (poly_rem(shifted) == '0);
							state_d = ST_CORR;
						end
					end
				end
			end
			ST_CORR: begin
				buf_d = buf_q ^ flip_mask;
				pos_d = pos_q + 1'b1;
				fix_d = fix_q || hit;
				if (corr_done) begin
					err_d   = !(fix_q || hit);
					state_d = ST_EMIT;
				end
			end
			ST_EMIT: begin
				if (push) begin
					buf_d  = emit_next;
					ocnt_d = ocnt_q + 1'b1;
					if (push_last) begin
						state_d = ST_RECV;
					end
				end
			end
			default: begin
				state_d = ST_RECV;
			end
		endcase
	end

	// state registers; synchronous reset drops any partial packet
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q <= ST_RECV;
			cnt_q   <= '0;
			ocnt_q  <= '0;
			buf_q   <= '0;
			syn_q   <= '0;
			pos_q   <= '0;
			fix_q   <= 1'b0;
			err_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			ocnt_q  <= ocnt_d;
			buf_q   <= buf_d;
			syn_q   <= syn_d;
			pos_q   <= pos_d;
			fix_q   <= fix_d;
			err_q   <= err_d;
		end
	end

	// output buffer: a stalled sink fills it, then emission pauses
	bsc_fifo #(
		.W     (FW),
		.DEPTH (DEPTH)
	) u_fifo (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.wr      (wr_s),
		.rd      (rd_s)
	);

	// head of the buffer drives the sink directly
	assign head       = rd_s.data;
	assign rd_s.ready = out_ready;
	assign out_valid  = rd_s.valid;
	assign out_data   = head[FLAG_BITS +: D];
	assign out_sop    = rd_s.valid && head[FLD_SOP];
	assign out_eop    = rd_s.valid && head[FLD_EOP];
	assign out_error  = rd_s.valid && head[FLD_ERR];

	// in_sop and in_eop are framing hints only; word counting defines the packet
	logic unused_flags;
	assign unused_flags = in_sop ^ in_eop;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_len_legal: assert property (N <= (2 ** M) - 1 && N > P)
		else $error("codeword length exceeds full code length");

	// input side: ready, word counting and the final word slot
	a_ready_drop: assert property (take && cnt_q == CW'(X_IN - 2) && (X_IN > 1) |=>
		!in_ready)
		else $error("ready still high after the next to last word");

	a_final_taken: assert property (last_pend && in_valid |=> state_q != ST_RECV)
		else $error("final word after ready drop was not taken");

	// a stray word may meet the cycle in which ready comes back, so ready is judged now
	a_busy_ignore: assert property (!recv && in_valid |->
		!in_ready ##1 cnt_q == '0)
		else $error("input accepted while busy");

	a_busy_ready: assert property (state_q != ST_RECV |-> !in_ready)
		else $error("ready high while busy");

	a_ready_back: assert property (push_last && (X_IN > 1) |=>
		in_ready)
		else $error("ready did not return after the last word");

	a_word_count: assert property (take && !last_pend |=> cnt_q == $past(cnt_q) + 1'b1)
		else $error("accepted word not counted");

	a_in_hold: assert property (recv && !in_valid |=>
		cnt_q == $past(cnt_q))
		else $error("word counted without valid");

	// output side: stall, framing and flags
	a_stall_hold: assert property (out_valid && !out_ready |=>
		out_valid && $stable(out_data) && $stable(out_sop) && $stable(out_eop)
		&& $stable(out_error))
		else $error("output changed while stalled");

	a_flags_valid: assert property (out_sop || out_eop || out_error |->
		out_valid)
		else $error("packet flag without valid word");

	a_sop_single: assert property (out_valid && out_sop && out_ready && (X_OUT > 1) |=>
		!out_sop)
		else $error("start flag longer than one word");

	a_sop_order: assert property (out_valid && out_ready && !out_eop |=>
		!out_sop)
		else $error("start flag inside a codeword");

	a_eop_next: assert property (out_valid && out_ready && out_eop |=>
		!out_valid || out_sop)
		else $error("codeword after end flag lacks start flag");

	// code checks on the word about to leave
	a_enc_parity: assert property (ENCODER && state_q == ST_EMIT && ocnt_q == '0 |->
		poly_rem({{P{1'b0}}, buf_q[N-1 -: K]}) == buf_q[P-1:0])
		else $error("encoder check bits wrong");

	a_enc_no_err: assert property (ENCODER |-> !out_error)
		else $error("encoder raised the error flag");

	a_dec_fixed: assert property (!ENCODER && state_q == ST_EMIT && ocnt_q == '0
		&& !err_q |-> poly_rem(buf_q) == '0)
		else $error("decoder emitted a non-codeword unflagged");

	a_dec_flag: assert property (!ENCODER && state_q == ST_EMIT && ocnt_q == '0
		&& err_q |-> poly_rem(buf_q) != '0)
		else $error("decoder flagged a clean codeword");

	a_err_steady: assert property (state_q == ST_EMIT |=>
		$stable(err_q))
		else $error("error flag changed inside a codeword");

	a_clean_pass: assert property (state_q == ST_CORR && fix_q |=>
		state_q == ST_EMIT)
		else $error("clean codeword held in the search");

	a_corr_bound: assert property ($rose(state_q == ST_CORR) |->
		##[1:CORR_MAX] state_q == ST_EMIT)
		else $error("correction search did not finish");

	// main scenarios: whole packet, stalled sink, fix, flag, clean pass
	c_packet: cover property (push_last);
	c_stall: cover property (out_valid && !out_ready ##1 out_valid && out_ready);
	c_fixed: cover property (state_q == ST_CORR && hit);
	c_uncorr: cover property (out_valid && out_sop && out_error);
	c_clean: cover property (state_q == ST_CORR && fix_q);

endmodule

/* File: bsc_sink_model.sv */
`timescale 1ns/1ps
// downstream sink: gathers one codeword, may throttle, watches a stalled output word
module bsc_sink_model (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       stall,
	input  wire logic       clr,
	input  wire logic [0:0] out_data,
	input  wire logic       out_valid,
	input  wire logic       out_sop,
	input  wire logic       out_eop,
	input  wire logic       out_error,
	output logic            out_ready,
	output logic [14:0]     cw,
	output logic [7:0]      words,
	output logic [7:0]      sops,
	output logic [7:0]      eops,
	output logic [7:0]      errs,
	output logic [7:0]      hold_bad
);
	logic [1:0] ph = 2'h0;
	logic [3:0] last;
	logic       held;
	initial out_ready = 1'b0;
	// slow mode accepts one cycle in three, so the core must sit on its word
	always @(negedge ref_clk) begin
		ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
		out_ready <= !stall || (ph == 2'h0);
	end
	// count popped words; a stalled word must look the same one cycle later
	always @(posedge ref_clk) begin
		if (!rst_n || clr) begin
			{cw, words, sops, eops, errs, hold_bad} <= '0;
			held <= 1'b0;
		end else begin
			if (held && last !== {out_valid, out_sop, out_eop, out_data})
				hold_bad <= hold_bad + 8'h01;
			held <= out_valid && !out_ready;
			last <= {out_valid, out_sop, out_eop, out_data};
			if (out_valid && out_ready) begin
				cw    <= {cw[13:0], out_data};
				words <= words + 8'h01;
				sops  <= sops + out_sop;
				eops  <= eops + out_eop;
				errs  <= errs + out_error;
			end
		end
	end
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
	import bsc_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        in_sop = 1'b0;
	logic        in_eop = 1'b0;
	logic        stall = 1'b0;
	logic        clr = 1'b0;
	logic [0:0]  in_data = 1'b0;
	logic [1:0]  vld = 2'h0;
	logic [1:0]  rdy, ov, os, oe, oerr, ordy;
	logic [0:0]  od [2];
	logic [14:0] cw [2];
	logic [7:0]  nw [2], ns [2], ne [2], nerr [2], hb [2];
	int          error_cnt = 0;
	int          tests_run = 0;

	always #50 ref_clk = ~ref_clk;

	// index 0: full-length encoder, index 1: decoder built for a shortened length
	bsc_codec #(.ENCODER(MODE_ENCODER)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
		.in_data(in_data), .in_valid(vld[0]), .in_sop(in_sop), .in_eop(in_eop),
		.in_ready(rdy[0]), .out_data(od[0]), .out_valid(ov[0]), .out_sop(os[0]),
		.out_eop(oe[0]), .out_error(oerr[0]), .out_ready(ordy[0]));
	bsc_codec #(.ENCODER(MODE_DECODER), .N(12), .K(4)) uut_dec (.ref_clk(ref_clk),
		.rst_n(rst_n), .in_data(in_data), .in_valid(vld[1]), .in_sop(in_sop),
		.in_eop(in_eop), .in_ready(rdy[1]), .out_data(od[1]), .out_valid(ov[1]),
		.out_sop(os[1]), .out_eop(oe[1]), .out_error(oerr[1]), .out_ready(ordy[1]));
	for (genvar g = 0; g < 2; g++) begin : g_sink
		bsc_sink_model sink (.ref_clk(ref_clk), .rst_n(rst_n), .stall(stall), .clr(clr),
			.out_data(od[g]), .out_valid(ov[g]), .out_sop(os[g]), .out_eop(oe[g]),
			.out_error(oerr[g]), .out_ready(ordy[g]), .cw(cw[g]), .words(nw[g]),
			.sops(ns[g]), .eops(ne[g]), .errs(nerr[g]), .hold_bad(hb[g]));
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// check bits: remainder of the left-aligned word by the generator
	function automatic logic [7:0] rem(input logic [14:0] v);
		for (int i = 14; i >= 8; i--)
			if (v[i])
				v ^= 15'(DEF_GEN) << (i - 8);
		return v[7:0];
	endfunction

	task automatic start(input logic slow);
		@(negedge ref_clk);
		stall = slow;
		clr = 1'b1;
		@(negedge ref_clk);
		clr = 1'b0;
	endtask

	// x words msb first, then stray words while ready is low must leave no trace
	task automatic send(input int u, input logic [14:0] v, input int x);
		for (int i = x - 1; i >= 0; i--) begin
			@(negedge ref_clk);
			vld[u] = 1'b1;
			in_data = v[i];
			in_sop = (i == x - 1);
			in_eop = (i == 0);
			#1 chk("in_ready", rdy[u], i != 0);
		end
		@(negedge ref_clk);
		in_data = ~in_data;
		in_sop = 1'b1;
		in_eop = 1'b0;
		repeat (2) @(negedge ref_clk);
		vld[u] = 1'b0;
		in_sop = 1'b0;
	endtask

	task automatic wait_out(input int u, input int n);
		int k;
		k = 0;
		while (nw[u] !== n && k < 400) begin
			@(posedge ref_clk);
			k++;
		end
		#1;
		chk("words", nw[u], n);
		chk("sop count", ns[u], 1);
		chk("eop count", ne[u], 1);
		chk("out_valid idle", ov[u], 0);
		chk("stalled word held", hb[u], 0);
	endtask

	task automatic t_enc(input logic [6:0] msg, input logic slow);
		start(slow);
		send(0, {8'h00, msg}, 7);
		wait_out(0, 15);
		chk("enc codeword", cw[0], {msg, rem({msg, 8'h00})});
		chk("enc error", nerr[0], 0);
		$display("test t_enc %h done", msg);
	endtask

	// shortened (12,4): codeword is the (15,7) code with three leading zero bits
	task automatic t_dec(input logic [3:0] msg, input logic [11:0] err);
		logic [14:0] c;
		logic [14:0] p;
		logic        bad;
		c = {3'h0, msg, rem({3'h0, msg, 8'h00})};
		bad = 1'b1;
		for (int a = 0; a < 13; a++)
			for (int b = a; b < 13; b++) begin
				p = (a < 12 ? 15'h0001 << a : 15'h0000) ^ (b < 12 ? 15'h0001 << b : 15'h0000);
				if (rem(p) == rem({3'h0, err}))
					bad = 1'b0;
			end
		start(1'b0);
		send(1, c ^ err, 12);
		wait_out(1, 12);
		chk("dec error flag", nerr[1], bad ? 12 : 0);
		if (!bad)
			chk("dec codeword", cw[1], c);
		$display("test t_dec %h %h done", msg, err);
	endtask

	task automatic t_reset;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		rst_n = 1'b1;
		#1 chk("reset ready", rdy, 2'h3);
		chk("reset valid", ov, 2'h0);
		$display("test t_reset done");
	endtask

	// partial packet cut by a reset; the next whole packet must be clean
	task automatic t_cut;
		@(negedge ref_clk);
		vld[0] = 1'b1;
		repeat (3) @(negedge ref_clk);
		vld[0] = 1'b0;
		rst_n = 1'b0;
		@(negedge ref_clk);
		rst_n = 1'b1;
		#1 chk("cut ready", rdy, 2'h3);
		chk("cut valid", ov, 2'h0);
		$display("test t_cut done");
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#2_000_000;
		error_cnt++;
		close_out;
	end

	initial begin
		t_reset;
		t_enc(7'h5a, 1'b1);
		t_cut;
		t_enc(7'h7f, 1'b0);
		t_enc(7'h01, 1'b1);
		t_dec(4'h9, 12'h000);
		t_dec(4'h6, 12'h800);
		t_dec(4'hd, 12'h401);
		t_dec(4'h3, 12'h007);
		t_dec(4'ha, 12'h0f0);
		close_out;
	end
endmodule
